// *** cthl_consts.vh ***
/*
 * constants of the cross-trigger halt logic: action and event bit numbers,
 * profiling control bit positions and the reset values of the run states.
 * assumes inclusion by bare name from the design files.
 */
`ifndef CTHL_CONSTS_VH
`define CTHL_CONSTS_VH

`define CTHL_XT_W        8
`define CTHL_ACT_STOP    0
`define CTHL_ACT_RESUME  1
`define CTHL_ACT_TR_OFF  2
`define CTHL_ACT_TR_ON   3
`define CTHL_ACT_PM_OFF  4
`define CTHL_ACT_PM_ON   5
`define CTHL_ACT_PR_OFF  6
`define CTHL_ACT_PR_ON   7

`define CTHL_EVT_HALT    0
`define CTHL_EVT_RESUME  1
`define CTHL_EVT_TR_OFF  2
`define CTHL_EVT_TR_ON   3
`define CTHL_EVT_PM_OFF  4
`define CTHL_EVT_PM_ON   5
`define CTHL_EVT_PR_OFF  6
`define CTHL_EVT_PR_ON   7

`define CTHL_PCTRL_W     8
`define CTHL_PCTRL_EN    7
`define CTHL_PCTRL_DIS   6

`define CTHL_HALT_DEPTH  3
`define CTHL_RST_OFF     1'b0

`endif

// *** cthl_sync_rst.v ***
/*
 * reset release synchroniser: asserts asynchronously, releases through
 * two flip-flops on the clock.
 * assumes a free-running clock while reset is released.
 */
`timescale 1ns/10ps
`default_nettype none
module cthl_sync_rst (
	input  wire clk_i,
	input  wire rst_n_i,
	output wire rst_n_o
);
	reg meta_q;
	reg sync_q;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= 1'b1;
			sync_q <= meta_q;
		end
	end

	assign rst_n_o = sync_q;
endmodule // cthl_sync_rst
`default_nettype wire

// *** cthl_run_flag.v ***
/*
 * one on/off run state with start and stop requests; emits a one-cycle
 * pulse on each real change. a request for the current state is ignored.
 * assumes synchronous requests and an already synchronised reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cthl_consts.vh"
module cthl_run_flag (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire start_i,
	input  wire stop_i,
	output reg  run_o,
	output reg  started_o,
	output reg  stopped_o
);
	// stop wins when both arrive together: the safe direction
	wire go_on  = start_i & ~stop_i & ~run_o;
	wire go_off = stop_i & run_o;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_o     <= `CTHL_RST_OFF;
			started_o <= 1'b0;
			stopped_o <= 1'b0;
		end else begin
			started_o <= go_on;   // [RQ18]
			stopped_o <= go_off;  // [RQ18]
			if (go_on)
				run_o <= 1'b1;
			else if (go_off)
				run_o <= 1'b0;
		end
	end
endmodule // cthl_run_flag
`default_nettype wire

// *** cthl_top.v ***
/*
 * cross-trigger and halt logic of a soft processor core: halt request
 * input, halted indicator, eight actions in and eight events out, plus
 * run states of trace, performance monitoring and profiling.
 * assumes all inputs synchronous to ref_clk_i and the external debug
 * module in the same clock domain; action lines are one-cycle pulses or
 * levels, each cycle high counts as a request.
 */
// Summary of operation
// [RQ1] halt request input stops core into halt
// [RQ2] halted indicator high whenever core is halted
// [RQ3] debugger resume clears the halted indicator; code ignores resume while halt_req_i is high
// [RQ4] eight actions accepted from debug module
// [RQ5] eight events reported to debug module
// [RQ6] action 0 halts, same as halt input
// [RQ7] action 1 resumes and clears halted indicator; code ignores it while halt_req_i is high
// [RQ8] actions 2,3 stop and start trace
// [RQ9] actions 4,5 stop and start perf monitoring
// [RQ10] actions 6,7 disable and enable profiling
// [RQ11] event 0 pulses as halted indicator sets
// [RQ12] event 1 pulses as halted indicator clears
// [RQ13] event 2 pulses when trace stops
// [RQ14] event 3 pulses when trace starts
// [RQ15] events 4,5 on perf monitor stop, start
// [RQ16] event 6 disabled, event 7 enabled profiling
// [RQ17] profiling control bit 7 enables, 6 disables
// [RQ18] events are single pulses; redundant actions ignored
`timescale 1ns/10ps
`default_nettype none
`include "cthl_consts.vh"
module cthl_top #(
	parameter HALT_DEPTH = `CTHL_HALT_DEPTH
) (
	input  wire                      ref_clk_i,
	input  wire                      rst_n_i,
	input  wire                      halt_req_i,
	input  wire                      dbg_stop_cmd_i,
	input  wire                      dbg_resume_cmd_i,
	input  wire                      bkpt_hit_i,
	input  wire                      instr_retire_i,
	input  wire [`CTHL_XT_W-1:0]     xt_action_i,
	input  wire                      trace_start_cmd_i,
	input  wire                      trace_stop_cmd_i,
	input  wire                      tracepoint_hit_i,
	input  wire                      trace_full_i,
	input  wire                      perf_start_cmd_i,
	input  wire                      perf_stop_cmd_i,
	input  wire                      pctrl_wr_i,
	input  wire [`CTHL_PCTRL_W-1:0]  pctrl_data_i,
	output reg                       halted_indicator_o,
	output reg                       core_stall_o,
	output reg                       trace_run_o,
	output reg                       perf_run_o,
	output reg                       prof_run_o,
	output reg  [`CTHL_XT_W-1:0]     xt_event_o
);

	////////////////////////////////////////////////////////////////////////
	// reset

	wire rst_n;

	cthl_sync_rst u_rst (
		.clk_i   (ref_clk_i),
		.rst_n_i (rst_n_i),
		.rst_n_o (rst_n)
	);

	////////////////////////////////////////////////////////////////////////
	// halt state machine

	localparam [1:0] ST_RUN     = 2'b00;
	localparam [1:0] ST_DRAIN   = 2'b01;
	localparam [1:0] ST_HALTED  = 2'b10;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [3:0] drain_q;
	reg [3:0] drain_d;

	// halt sources: halt input level, action 0, debugger stop, breakpoint
	wire stop_req = halt_req_i                         // [RQ1]
		| xt_action_i[`CTHL_ACT_STOP]                   // [RQ4] [RQ6]
		| dbg_stop_cmd_i
		| bkpt_hit_i;                                   // [RQ2]
	wire resume_req = dbg_resume_cmd_i                 // [RQ3]
		| xt_action_i[`CTHL_ACT_RESUME];                // [RQ7]

	wire enter_halt;
	wire leave_halt;

	// halted decode is needed for the indicator, the stall and both events
	function is_halted;
		input [1:0] st;
		begin
			is_halted = (st == ST_HALTED);
		end
	endfunction

	// the core finishes a few instructions before it stops; a breakpoint still high
	// while draining stops at once since the hit instruction must not complete
	assign enter_halt = (state_q == ST_DRAIN) &&
		(drain_q == 4'h0 || bkpt_hit_i);
	// a held halt request keeps the core halted; resume cannot override it
	assign leave_halt = (state_q == ST_HALTED) && resume_req && !halt_req_i;

	always @* begin
		state_d = state_q;
		drain_d = drain_q;
		case (state_q)
			ST_RUN: begin
				if (stop_req) begin
					state_d = ST_DRAIN;  // [RQ1]
					drain_d = HALT_DEPTH[3:0];
				end
			end
			ST_DRAIN: begin
				if (enter_halt)
					state_d = ST_HALTED;
				else if (instr_retire_i)
					drain_d = drain_q - 4'h1;
			end
			ST_HALTED: begin
				if (leave_halt)
					state_d = ST_RUN;    // [RQ3] [RQ7]
			end
			default: begin
				state_d = ST_RUN;
				drain_d = 4'h0;
			end
		endcase
	end

	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_RUN;
			drain_q <= 4'h0;
			halted_indicator_o <= 1'b0;
			core_stall_o       <= 1'b0;
		end else begin
			state_q <= state_d;
			drain_q <= drain_d;
			halted_indicator_o <= is_halted(state_d);  // [RQ2] [RQ3]
			core_stall_o       <= is_halted(state_d);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trace, performance and profiling run states

	wire tr_run;
	wire tr_on_p;
	wire tr_off_p;
	wire pm_run;
	wire pm_on_p;
	wire pm_off_p;
	wire pr_run;
	wire pr_on_p;
	wire pr_off_p;

	wire pr_wr_on  = pctrl_wr_i & pctrl_data_i[`CTHL_PCTRL_EN];   // [RQ17]
	wire pr_wr_off = pctrl_wr_i & pctrl_data_i[`CTHL_PCTRL_DIS];  // [RQ17]

	cthl_run_flag u_trace (
		.clk_i     (ref_clk_i),
		.rst_n_i   (rst_n),
		.start_i   (trace_start_cmd_i | tracepoint_hit_i |
		            xt_action_i[`CTHL_ACT_TR_ON]),               // [RQ8]
		.stop_i    (trace_stop_cmd_i | trace_full_i |
		            xt_action_i[`CTHL_ACT_TR_OFF]),              // [RQ8]
		.run_o     (tr_run),
		.started_o (tr_on_p),
		.stopped_o (tr_off_p)
	);

	cthl_run_flag u_perf (
		.clk_i     (ref_clk_i),
		.rst_n_i   (rst_n),
		.start_i   (perf_start_cmd_i | xt_action_i[`CTHL_ACT_PM_ON]),  // [RQ9]
		.stop_i    (perf_stop_cmd_i | xt_action_i[`CTHL_ACT_PM_OFF]),  // [RQ9]
		.run_o     (pm_run),
		.started_o (pm_on_p),
		.stopped_o (pm_off_p)
	);

	cthl_run_flag u_prof (
		.clk_i     (ref_clk_i),
		.rst_n_i   (rst_n),
		.start_i   (pr_wr_on | xt_action_i[`CTHL_ACT_PR_ON]),    // [RQ10]
		.stop_i    (pr_wr_off | xt_action_i[`CTHL_ACT_PR_OFF]),  // [RQ10]
		.run_o     (pr_run),
		.started_o (pr_on_p),
		.stopped_o (pr_off_p)
	);

	////////////////////////////////////////////////////////////////////////
	// events: all registered so they line up with the run outputs

	wire halt_p   = !is_halted(state_q) && is_halted(state_d);
	wire resume_p = is_halted(state_q) && !is_halted(state_d);

	always @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			xt_event_o  <= {`CTHL_XT_W{1'b0}};
			trace_run_o <= `CTHL_RST_OFF;
			perf_run_o  <= `CTHL_RST_OFF;
			prof_run_o  <= `CTHL_RST_OFF;
		end else begin
			// [RQ5] [RQ18]
			xt_event_o[`CTHL_EVT_HALT]   <= halt_p;    // [RQ11]
			xt_event_o[`CTHL_EVT_RESUME] <= resume_p;  // [RQ12]
			xt_event_o[`CTHL_EVT_TR_OFF] <= tr_off_p;  // [RQ13]
			xt_event_o[`CTHL_EVT_TR_ON]  <= tr_on_p;   // [RQ14]
			xt_event_o[`CTHL_EVT_PM_OFF] <= pm_off_p;  // [RQ15]
			xt_event_o[`CTHL_EVT_PM_ON]  <= pm_on_p;   // [RQ15]
			// names win over the swapped descriptions
			xt_event_o[`CTHL_EVT_PR_OFF] <= pr_off_p;  // [RQ16]
			xt_event_o[`CTHL_EVT_PR_ON]  <= pr_on_p;   // [RQ16]
			trace_run_o <= tr_run;
			perf_run_o  <= pm_run;
			prof_run_o  <= pr_run;
		end
	end

endmodule // cthl_top
`default_nettype wire

// *** cthl_top_sva.sv ***
/* port checker for cthl_top. assumes bind onto cthl_top, one clock. */
`timescale 1ns/10ps
`default_nettype none
module cthl_top_sva #(parameter HALT_DEPTH = 3) (
	input wire logic       ref_clk_i,
	input wire logic       rst_n_i,
	input wire logic       halt_req_i,
	input wire logic       dbg_resume_cmd_i,
	input wire logic       instr_retire_i,
	input wire logic [7:0] xt_action_i,
	input wire logic       trace_stop_cmd_i,
	input wire logic       trace_full_i,
	input wire logic       pctrl_wr_i,
	input wire logic [7:0] pctrl_data_i,
	input wire logic       halted_indicator_o,
	input wire logic       trace_run_o,
	input wire logic       perf_run_o,
	input wire logic       prof_run_o,
	input wire logic [7:0] xt_event_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////
	// repetition fixed for the default depth of three retires plus take
	sequence s_stop;
		xt_action_i[0] && !halted_indicator_o;
	endsequence
	sequence s_drain;
		(instr_retire_i && !xt_action_i[1] && !dbg_resume_cmd_i)[*4];
	endsequence
	a_halt_drain: assert property (s_stop ##1 s_drain |=> halted_indicator_o)
		else $error("halt not reached after drain");
	a_req_holds: assert property (halted_indicator_o && halt_req_i |=> halted_indicator_o)
		else $error("halt left while request high");
	a_resume_drop: assert property ((xt_action_i[1] || dbg_resume_cmd_i) &&
		halted_indicator_o && !halt_req_i |=> !halted_indicator_o && xt_event_o[1])
		else $error("resume not taken");
	a_halt_event: assert property (xt_event_o[0] == $rose(halted_indicator_o))
		else $error("halt event mismatch");
	a_trace_event: assert property (xt_event_o[3:2] == {$rose(trace_run_o), $fell(trace_run_o)})
		else $error("trace event mismatch");
	a_perf_event: assert property (xt_event_o[5:4] == {$rose(perf_run_o), $fell(perf_run_o)})
		else $error("perf event mismatch");
	a_prof_event: assert property (xt_event_o[7:6] == {$rose(prof_run_o), $fell(prof_run_o)})
		else $error("profiling event mismatch");
	a_trace_act: assert property (xt_action_i[3] && !xt_action_i[2] && !trace_stop_cmd_i &&
		!trace_full_i |-> ##2 trace_run_o) else $error("trace start lost");
	a_prof_write: assert property (pctrl_wr_i && pctrl_data_i[7] && !pctrl_data_i[6] &&
		!xt_action_i[6] |-> ##2 prof_run_o) else $error("profiling enable lost");
	a_pulse_once: assert property ((xt_event_o & $past(xt_event_o)) == 8'h00)
		else $error("event longer than one cycle");
endmodule // cthl_top_sva
bind cthl_top cthl_top_sva #(.HALT_DEPTH(HALT_DEPTH)) i_sva (.*);
`default_nettype wire

// *** cthl_xdm_model.sv ***
/* debug module model: replays requested actions one edge later, counts
 event pulses. assumes requests set just after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module cthl_xdm_model (
	input  wire logic        clk_i,
	input  wire logic [7:0]  req_i,
	input  wire logic [7:0]  evt_i,
	output var  logic [7:0]  act_o,
	output var  logic [15:0] evt_cnt_o
);
	initial act_o = 8'h00;
	initial evt_cnt_o = 16'h0000;
	always @(posedge clk_i) begin
		act_o <= #1 req_i;
		evt_cnt_o <= evt_cnt_o + 16'($countones(evt_i));
	end
endmodule // cthl_xdm_model
`default_nettype wire

// *** cthl_top_tb.sv ***
/* testbench of cthl_top: halt sources, resume, random run-state traffic.
 assumes cthl_top and the debug module model compiled before. */
`timescale 1ns/10ps
`default_nettype none
module cthl_top_tb;
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0, halt_req_i = 1'b0, dbg_stop_cmd_i = 1'b0;
	logic dbg_resume_cmd_i = 1'b0, bkpt_hit_i = 1'b0, instr_retire_i = 1'b0, pctrl_wr_i = 1'b0;
	logic trace_start_cmd_i = 1'b0, trace_stop_cmd_i = 1'b0, tracepoint_hit_i = 1'b0;
	logic trace_full_i = 1'b0, perf_start_cmd_i = 1'b0, perf_stop_cmd_i = 1'b0;
	logic [7:0] pctrl_data_i = 8'h00, req = 8'h00, xt_action_i, xt_event_o;
	logic halted_indicator_o, core_stall_o, trace_run_o, perf_run_o, prof_run_o;
	logic [15:0] evt_cnt;
	logic [31:0] r;
	logic st [3];
	int fail_count = 0, num_checks = 0, seed = 25, ev = 6, i, k;
	always #25 ref_clk_i = ~ref_clk_i;
	cthl_top i_dut (.*);
	cthl_xdm_model i_xdm (.clk_i(ref_clk_i), .req_i(req), .evt_i(xt_event_o),
		.act_o(xt_action_i), .evt_cnt_o(evt_cnt));
	////////////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#2;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// stop beats start in one cycle; each real change is one event
	task upd(input int j, input logic s, input logic p);
		logic n;
		n = p ? 1'b0 : (s ? 1'b1 : st[j]);
		ev += int'(n != st[j]);
		st[j] = n;
	endtask
	task finish_test;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		fail_count++;
		finish_test;
	end
	initial begin
		st = '{1'b0, 1'b0, 1'b0};
		repeat (5) @(posedge ref_clk_i);
		#2 rst_n_i = 1'b1;
		cyc(3);
		for (k = 0; k < 3; k++) begin
			instr_retire_i = (k != 2);
			if (k == 0) req = 8'h01;
			else if (k == 1) halt_req_i = 1'b1;
			else dbg_stop_cmd_i = 1'b1;
			cyc(1);
			req = 8'h00;
			dbg_stop_cmd_i = 1'b0;
			if (k == 2) begin
				cyc(2);
				chk(16'(halted_indicator_o), 16'h0000);
				bkpt_hit_i = 1'b1;
				cyc(1);
				bkpt_hit_i = 1'b0;
			end
			cyc(6);
			chk(16'({halted_indicator_o, core_stall_o}), 16'h0003);
			req = 8'h02;
			cyc(1);
			req = 8'h00;
			cyc(3);
			chk(16'(halted_indicator_o), 16'(k == 1));
			halt_req_i = 1'b0;
			dbg_resume_cmd_i = 1'b1;
			cyc(1);
			dbg_resume_cmd_i = 1'b0;
			cyc(2);
			chk(16'(halted_indicator_o), 16'h0000);
		end
		$display("halt test done");
		for (i = 0; i < 20; i++) begin
			r = $random(seed);
			if (i < 2) r = 32'h000000A8;
			else if (i == 2) r = 32'h000000FC;
			req = r[7:0] & 8'hFC;
			{trace_start_cmd_i, trace_stop_cmd_i, tracepoint_hit_i, trace_full_i,
				perf_start_cmd_i, perf_stop_cmd_i, pctrl_wr_i} = r[14:8];
			pctrl_data_i = r[23:16];
			upd(0, r[14] | r[12], r[13] | r[11]);
			upd(1, r[10], r[9]);
			upd(2, r[8] & r[23], r[8] & r[22]);
			upd(0, r[3], r[2]);
			upd(1, r[5], r[4]);
			upd(2, r[7], r[6]);
			cyc(1);
			req = 8'h00;
			{trace_start_cmd_i, trace_stop_cmd_i, tracepoint_hit_i, trace_full_i,
				perf_start_cmd_i, perf_stop_cmd_i, pctrl_wr_i} = 7'h00;
			cyc(3);
			chk(16'({trace_run_o, perf_run_o, prof_run_o}), 16'({st[0], st[1], st[2]}));
		end
		$display("random test done");
		cyc(2);
		chk(evt_cnt, 16'(ev));
		finish_test;
	end
endmodule // cthl_top_tb
`default_nettype wire
